// >>> pkg/icd_pkg.sv
// Purpose: Constants and types for the image capture DMA channel register block.
// Assumes: Avalon-MM word addressing, 250 MHz clock.
// Notes:   Offsets below are word indices; byte address is four times the index.
//
// Functional notes
// - Writing one to off-register bit 1 disables the codec channel; poll status.
// - Status register bit 0 preview, bit 1 codec enabled; resets to zero.
// - Preview image base address held in bits 31..2; bits 1..0 reserved.
// - Codec image base address held in bits 31..2; low bits reserved, reset zero.
// - Preview descriptor address held word aligned in bits 31..2.
// - Codec descriptor address held word aligned in bits 31..2.
// - Preview control bit 0 enables descriptor fetch.
// - Preview control bit 1 enables descriptor writeback.
// - Preview control bit 2 set suppresses the preview done flag.
// - Preview descriptor word bit 3 written as one at transfer end if writeback.
// - Codec control bit 0 enables descriptor fetch.
// - Codec control bit 1 enables descriptor writeback.
// - Codec control bit 2 set suppresses the codec done flag.
// - Codec descriptor word bit 3 written as one at transfer end if writeback.
// - Protection control bit 0 turns protection on or off when key matches.
// - Key 0x495349 in bits 31..8 required; other keys ignore the write.
// - Violation kind 1 records blocked protected write; status read clears all.
// - Kind 2 records software reset while protected; 3 when both occurred.
// - Violation origin codes 1..9 name last offending protected register; 0 none.
// - Writing one to off-register bit 0 disables the preview channel.
// - Writing one to on-register bit 0 or 1 enables that channel; zero no effect.
// - Sync pending set while a status change settles; changes refused meanwhile.
package icd_pkg;
  localparam int          ADDR_W        = 5;
  localparam int          NUM_CH        = 2;
  localparam int          NUM_PROT      = 9;
  // Register word indices
  localparam logic [4:0]  IDX_CHAN_ON   = 5'h00;
  localparam logic [4:0]  IDX_CHAN_OFF  = 5'h01;
  localparam logic [4:0]  IDX_CHAN_STAT = 5'h02;
  localparam logic [4:0]  IDX_P_BASE    = 5'h03;
  localparam logic [4:0]  IDX_P_CTRL    = 5'h04;
  localparam logic [4:0]  IDX_P_DESC    = 5'h05;
  localparam logic [4:0]  IDX_C_BASE    = 5'h06;
  localparam logic [4:0]  IDX_C_CTRL    = 5'h07;
  localparam logic [4:0]  IDX_C_DESC    = 5'h08;
  localparam logic [4:0]  IDX_WP_CTRL   = 5'h09;
  localparam logic [4:0]  IDX_WP_STAT   = 5'h0A;
  localparam logic [4:0]  IDX_SYNC_STAT = 5'h0B;
  localparam logic [4:0]  IDX_PROT_LO   = 5'h0C;
  localparam logic [4:0]  IDX_PROT_HI   = 5'h14;
  // Field positions
  localparam int          CTRL_FETCH    = 0;
  localparam int          CTRL_WB       = 1;
  localparam int          CTRL_MASK     = 2;
  localparam int          DESC_DONE     = 3;
  localparam int          WP_EN_POS     = 0;
  localparam int          WP_KEY_LO     = 8;
  localparam int          WP_SRC_LO     = 8;
  localparam logic [23:0] WP_KEY        = 24'h495349;
  localparam logic [1:0]  KIND_WRITE    = 2'h1;
  localparam logic [1:0]  KIND_SWRST    = 2'h2;
  localparam logic [31:0] RESET_WORD    = 32'h00000000;
  // Timing
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          SYNC_TIME_NS  = 16;
  localparam logic [3:0]  SYNC_CYCLES   = 4'((SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  typedef logic [NUM_PROT-1:0][31:0] icd_prot_t;
endpackage

// >>> hdl/icd_dma_regs.sv
// Purpose: Register interface of the preview and codec DMA channels with write protection.
// Assumes: Single clock, Avalon-MM slave with one wait state on every access.
// Notes:   Channel state changes are followed by a short settle window.
`timescale 1ns/100ps
`default_nettype none
module icd_dma_regs (
  input  wire logic                       SYS_CLK_IN,               // 250 MHz clock
  input  wire logic                       RST_IN,                   // Async reset, high
  input  wire logic [icd_pkg::ADDR_W-1:0] AVS_ADDRESS_IN,           // Word address
  input  wire logic                       AVS_READ_IN,              // Read request
  input  wire logic                       AVS_WRITE_IN,             // Write request
  input  wire logic [31:0]                AVS_WRITEDATA_IN,         // Write data
  input  wire logic [3:0]                 AVS_BYTEENABLE_IN,        // Byte lanes
  output logic      [31:0]                AVS_READDATA_OUT,         // Read data
  output logic                            AVS_WAITREQUEST_OUT,      // Stall
  input  wire logic                       SOFT_RST_EVENT_IN,        // Unit software reset pulse
  input  wire logic                       PREVIEW_XFER_END_IN,      // Preview transfer end
  input  wire logic                       CODEC_XFER_END_IN,        // Codec transfer end
  output logic                            PREVIEW_CHAN_STATE_OUT,   // Preview enabled
  output logic                            CODEC_CHAN_STATE_OUT,     // Codec enabled
  output logic                            SYNC_PENDING_OUT,         // Status settling
  output logic      [31:0]                PREVIEW_IMG_BASE_OUT,     // Preview base address
  output logic      [31:0]                PREVIEW_DESC_PTR_OUT,     // Preview descriptor
  output logic      [31:0]                CODEC_IMG_BASE_OUT,       // Codec base address
  output logic      [31:0]                CODEC_DESC_PTR_OUT,       // Codec descriptor
  output logic                            PREVIEW_FETCH_EN_OUT,     // Preview fetch on
  output logic                            CODEC_FETCH_EN_OUT,       // Codec fetch on
  output logic                            PREVIEW_DESC_WR_OUT,      // Preview writeback pulse
  output logic                            CODEC_DESC_WR_OUT,        // Codec writeback pulse
  output logic      [31:0]                PREVIEW_DESC_WORD_OUT,    // Preview control word
  output logic      [31:0]                CODEC_DESC_WORD_OUT,      // Codec control word
  output logic                            PREVIEW_DONE_FLAG_OUT,    // Preview done pulse
  output logic                            CODEC_DONE_FLAG_OUT,      // Codec done pulse
  output icd_pkg::icd_prot_t              PROT_CFG_OUT              // Protected settings
);
  import icd_pkg::*;

  typedef struct packed {
    logic                        ack;
    logic [31:0]                 rdata;
    logic [NUM_CH-1:0]           on;
    logic [3:0]                  sync_cnt;
    logic [NUM_CH-1:0][29:0]     base;
    logic [NUM_CH-1:0][29:0]     desc;
    logic [NUM_CH-1:0][2:0]      ctrl;
    logic [NUM_CH-1:0]           desc_wr;
    logic [NUM_CH-1:0][31:0]     desc_word;
    logic [NUM_CH-1:0]           done_flag;
    logic                        wp_en;
    logic [1:0]                  wp_kind;
    logic [3:0]                  wp_src;
    icd_prot_t                   prot;
  } icd_state_t;

  icd_state_t state_r;
  icd_state_t state_nxt;

  logic              req;
  logic              wr_go;
  logic              rd_go;
  logic [31:0]       be_mask;
  logic [NUM_CH-1:0] xfer_end;
  logic              pend;

  assign req      = AVS_READ_IN | AVS_WRITE_IN;
  assign wr_go    = AVS_WRITE_IN & state_r.ack;
  assign rd_go    = AVS_READ_IN & state_r.ack;
  assign xfer_end = {CODEC_XFER_END_IN, PREVIEW_XFER_END_IN};
  assign pend     = (state_r.sync_cnt != 4'h0);
  assign be_mask  = {{8{AVS_BYTEENABLE_IN[3]}}, {8{AVS_BYTEENABLE_IN[2]}},
                     {8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  function automatic logic [31:0] rd_mux(input icd_state_t s, input logic [4:0] a);
    logic [31:0] d;
    d = RESET_WORD;
    unique case (a)
      IDX_CHAN_STAT: d = {30'h0, s.on};
      IDX_P_BASE:    d = {s.base[0], 2'h0};
      IDX_P_CTRL:    d = {29'h0, s.ctrl[0]};
      IDX_P_DESC:    d = {s.desc[0], 2'h0};
      IDX_C_BASE:    d = {s.base[1], 2'h0};
      IDX_C_CTRL:    d = {29'h0, s.ctrl[1]};
      IDX_C_DESC:    d = {s.desc[1], 2'h0};
      IDX_WP_CTRL:   d = {31'h0, s.wp_en};
      IDX_WP_STAT:   d = {20'h0, s.wp_src, 6'h0, s.wp_kind};
      IDX_SYNC_STAT: d = {31'h0, s.sync_cnt != 4'h0};
      default: begin
        if (a >= IDX_PROT_LO && a <= IDX_PROT_HI) begin
          d = s.prot[4'(a - IDX_PROT_LO)];
        end
      end
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [3:0]  pidx;
    logic        viol;
    logic [31:0] wmix;
    pidx      = 4'h0;
    viol      = 1'b0;
    wmix      = 32'h0;
    state_nxt = state_r;
    state_nxt.ack = req & ~state_r.ack;
    if (req && !state_r.ack) begin
      state_nxt.rdata = rd_mux(state_r, AVS_ADDRESS_IN);
    end
    if (pend) begin
      state_nxt.sync_cnt = state_r.sync_cnt - 4'h1;
    end

    // Reading the protection status clears it; new events below still win
    if (rd_go && AVS_ADDRESS_IN == IDX_WP_STAT) begin
      state_nxt.wp_kind = 2'h0;
      state_nxt.wp_src  = 4'h0;
    end

    if (wr_go) begin
      unique case (AVS_ADDRESS_IN)
        IDX_CHAN_ON: begin
          if (!pend && AVS_BYTEENABLE_IN[0] && (AVS_WRITEDATA_IN[1:0] & ~state_r.on) != 2'h0) begin
            state_nxt.on       = state_r.on | AVS_WRITEDATA_IN[1:0];
            state_nxt.sync_cnt = SYNC_CYCLES;
          end
        end
        IDX_CHAN_OFF: begin
          if (!pend && AVS_BYTEENABLE_IN[0] && (AVS_WRITEDATA_IN[1:0] & state_r.on) != 2'h0) begin
            state_nxt.on       = state_r.on & ~AVS_WRITEDATA_IN[1:0];
            state_nxt.sync_cnt = SYNC_CYCLES;
          end
        end
        IDX_P_BASE: begin
          wmix = ({state_r.base[0], 2'h0} & ~be_mask) | (AVS_WRITEDATA_IN & be_mask);
          state_nxt.base[0] = wmix[31:2];
        end
        IDX_C_BASE: begin
          wmix = ({state_r.base[1], 2'h0} & ~be_mask) | (AVS_WRITEDATA_IN & be_mask);
          state_nxt.base[1] = wmix[31:2];
        end
        IDX_P_DESC: begin
          wmix = ({state_r.desc[0], 2'h0} & ~be_mask) | (AVS_WRITEDATA_IN & be_mask);
          state_nxt.desc[0] = wmix[31:2];
        end
        IDX_C_DESC: begin
          wmix = ({state_r.desc[1], 2'h0} & ~be_mask) | (AVS_WRITEDATA_IN & be_mask);
          state_nxt.desc[1] = wmix[31:2];
        end
        IDX_P_CTRL: begin
          if (AVS_BYTEENABLE_IN[0]) begin
            state_nxt.ctrl[0] = AVS_WRITEDATA_IN[2:0];
          end
        end
        IDX_C_CTRL: begin
          if (AVS_BYTEENABLE_IN[0]) begin
            state_nxt.ctrl[1] = AVS_WRITEDATA_IN[2:0];
          end
        end
        IDX_WP_CTRL: begin
          if (AVS_BYTEENABLE_IN == 4'hF && AVS_WRITEDATA_IN[31:WP_KEY_LO] == WP_KEY) begin
            state_nxt.wp_en = AVS_WRITEDATA_IN[WP_EN_POS];
          end
        end
        default: begin
          if (AVS_ADDRESS_IN >= IDX_PROT_LO && AVS_ADDRESS_IN <= IDX_PROT_HI) begin
            pidx = 4'(AVS_ADDRESS_IN - IDX_PROT_LO);
            if (state_r.wp_en) begin
              viol = 1'b1;
            end else begin
              state_nxt.prot[pidx] = (state_r.prot[pidx] & ~be_mask) | (AVS_WRITEDATA_IN & be_mask);
            end
          end
        end
      endcase
    end

    if (viol) begin
      state_nxt.wp_kind = state_nxt.wp_kind | KIND_WRITE;
      state_nxt.wp_src  = pidx + 4'h1;
    end
    if (SOFT_RST_EVENT_IN && state_r.wp_en) begin
      state_nxt.wp_kind = state_nxt.wp_kind | KIND_SWRST;
    end

    // Per channel transfer end: descriptor update and done flag
    for (int ch = 0; ch < NUM_CH; ch++) begin
      state_nxt.desc_wr[ch]   = xfer_end[ch] & state_r.on[ch] & state_r.ctrl[ch][CTRL_WB];
      state_nxt.done_flag[ch] = xfer_end[ch] & state_r.on[ch] & ~state_r.ctrl[ch][CTRL_MASK];
      if (xfer_end[ch]) begin
        state_nxt.desc_word[ch] = {28'h0, 1'b1, state_r.ctrl[ch]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign AVS_WAITREQUEST_OUT    = req & ~state_r.ack;
  assign AVS_READDATA_OUT       = state_r.rdata;
  assign PREVIEW_CHAN_STATE_OUT = state_r.on[0];
  assign CODEC_CHAN_STATE_OUT   = state_r.on[1];
  assign SYNC_PENDING_OUT       = pend;
  assign PREVIEW_IMG_BASE_OUT   = {state_r.base[0], 2'h0};
  assign CODEC_IMG_BASE_OUT     = {state_r.base[1], 2'h0};
  assign PREVIEW_DESC_PTR_OUT   = {state_r.desc[0], 2'h0};
  assign CODEC_DESC_PTR_OUT     = {state_r.desc[1], 2'h0};
  assign PREVIEW_FETCH_EN_OUT   = state_r.ctrl[0][CTRL_FETCH] & state_r.on[0];
  assign CODEC_FETCH_EN_OUT     = state_r.ctrl[1][CTRL_FETCH] & state_r.on[1];
  assign PREVIEW_DESC_WR_OUT    = state_r.desc_wr[0];
  assign CODEC_DESC_WR_OUT      = state_r.desc_wr[1];
  assign PREVIEW_DESC_WORD_OUT  = state_r.desc_word[0];
  assign CODEC_DESC_WORD_OUT    = state_r.desc_word[1];
  assign PREVIEW_DONE_FLAG_OUT  = state_r.done_flag[0];
  assign CODEC_DONE_FLAG_OUT    = state_r.done_flag[1];
  assign PROT_CFG_OUT           = state_r.prot;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);

  logic off_go;
  logic on_go;
  assign off_go = wr_go && AVS_ADDRESS_IN == IDX_CHAN_OFF && !pend && AVS_BYTEENABLE_IN[0];
  assign on_go  = wr_go && AVS_ADDRESS_IN == IDX_CHAN_ON && !pend && AVS_BYTEENABLE_IN[0];

  codec_off_a: assert property (off_go && AVS_WRITEDATA_IN[1] |=> !CODEC_CHAN_STATE_OUT)
    else $error("codec channel not disabled");
  preview_off_a: assert property (off_go && AVS_WRITEDATA_IN[0] |=> !PREVIEW_CHAN_STATE_OUT)
    else $error("preview channel not disabled");
  chan_on_a: assert property (on_go && AVS_WRITEDATA_IN[1:0] == 2'h2 && !CODEC_CHAN_STATE_OUT
                              |=> CODEC_CHAN_STATE_OUT && $stable(PREVIEW_CHAN_STATE_OUT))
    else $error("channel enable wrong");
  status_read_a: assert property (AVS_READ_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == IDX_CHAN_STAT
                                  |-> AVS_READDATA_OUT == {30'h0, CODEC_CHAN_STATE_OUT, PREVIEW_CHAN_STATE_OUT})
    else $error("channel status read wrong");
  addr_align_a: assert property (PREVIEW_IMG_BASE_OUT[1:0] == 2'h0 && CODEC_IMG_BASE_OUT[1:0] == 2'h0
                                 && PREVIEW_DESC_PTR_OUT[1:0] == 2'h0 && CODEC_DESC_PTR_OUT[1:0] == 2'h0)
    else $error("address low bits set");
  sync_hold_a: assert property ($rose(SYNC_PENDING_OUT) |-> SYNC_PENDING_OUT [*4] ##1 !SYNC_PENDING_OUT)
    else $error("sync window length wrong");
  pend_refuse_a: assert property (SYNC_PENDING_OUT |=> $stable({CODEC_CHAN_STATE_OUT, PREVIEW_CHAN_STATE_OUT})
                                  || $past(state_r.sync_cnt) == 4'h1)
    else $error("channel changed while pending");
  done_mask_a: assert property (PREVIEW_XFER_END_IN && PREVIEW_CHAN_STATE_OUT
                                |=> PREVIEW_DONE_FLAG_OUT == !$past(state_r.ctrl[0][CTRL_MASK]))
    else $error("preview done flag gating wrong");
  codec_wb_a: assert property (CODEC_XFER_END_IN && CODEC_CHAN_STATE_OUT && state_r.ctrl[1][CTRL_WB]
                               |=> CODEC_DESC_WR_OUT && CODEC_DESC_WORD_OUT[DESC_DONE])
    else $error("codec descriptor not marked done");
  bad_key_a: assert property (wr_go && AVS_ADDRESS_IN == IDX_WP_CTRL && AVS_WRITEDATA_IN[31:8] != WP_KEY
                              |=> $stable(state_r.wp_en))
    else $error("write protect changed with bad key");
  prot_block_a: assert property (wr_go && state_r.wp_en && AVS_ADDRESS_IN == IDX_PROT_HI
                                 |=> $stable(PROT_CFG_OUT) && state_r.wp_src == 4'h9 && state_r.wp_kind[0])
    else $error("protected write not blocked or recorded");
  swrst_rec_a: assert property (SOFT_RST_EVENT_IN && state_r.wp_en |=> state_r.wp_kind[1])
    else $error("software reset violation not recorded");

  ////////////////////////////////////////////////////////////////////////////
  // Read clear of the protection status, when no new event lands
  status_clear_a: assert property (rd_go && AVS_ADDRESS_IN == IDX_WP_STAT && !SOFT_RST_EVENT_IN
                                   |=> state_r.wp_kind == 2'h0 && state_r.wp_src == 4'h0)
    else $error("protection status not cleared by read");

  // Exactly one wait state per access
  one_wait_a: assert property (AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT)
    else $error("waitrequest held too long");

  // Key match applies the enable bit
  key_ok_a: assert property (wr_go && AVS_ADDRESS_IN == IDX_WP_CTRL && AVS_BYTEENABLE_IN == 4'hF
                             && AVS_WRITEDATA_IN[31:8] == WP_KEY
                             |=> state_r.wp_en == $past(AVS_WRITEDATA_IN[WP_EN_POS]))
    else $error("write protect enable not applied");

  // Codec fetch follows the control write while the channel is on
  codec_fetch_a: assert property (wr_go && AVS_ADDRESS_IN == IDX_C_CTRL && AVS_BYTEENABLE_IN[0]
                                  && CODEC_CHAN_STATE_OUT
                                  |=> CODEC_FETCH_EN_OUT == $past(AVS_WRITEDATA_IN[CTRL_FETCH]))
    else $error("codec fetch enable wrong");

  // Codec done flag gating
  codec_done_a: assert property (CODEC_XFER_END_IN && CODEC_CHAN_STATE_OUT
                                 |=> CODEC_DONE_FLAG_OUT == !$past(state_r.ctrl[1][CTRL_MASK]))
    else $error("codec done flag gating wrong");

  // Preview descriptor marked done on writeback
  preview_wb_a: assert property (PREVIEW_XFER_END_IN && PREVIEW_CHAN_STATE_OUT && state_r.ctrl[0][CTRL_WB]
                                 |=> PREVIEW_DESC_WR_OUT && PREVIEW_DESC_WORD_OUT[DESC_DONE])
    else $error("preview descriptor not marked done");

  // Fetch stays off for a disabled preview channel
  preview_idle_a: assert property (!PREVIEW_CHAN_STATE_OUT |-> !PREVIEW_FETCH_EN_OUT)
    else $error("preview fetch while channel off");

  cov_chan_cycle_c:  cover property (on_go ##[1:20] off_go);
  cov_violation_c:   cover property (wr_go && state_r.wp_en && AVS_ADDRESS_IN == IDX_PROT_LO);
  cov_status_clr_c:  cover property (rd_go && AVS_ADDRESS_IN == IDX_WP_STAT && state_r.wp_kind == 2'h3);
  cov_desc_write_c:  cover property (PREVIEW_DESC_WR_OUT);
  cov_sync_end_c:    cover property ($fell(SYNC_PENDING_OUT));
endmodule
`default_nettype wire

// >>> testbench/icd_mem_model.sv
// Purpose: System memory seen by one channel; ends its transfers and stores its descriptor words.
// Assumes: One clock; the bench asks for a transfer end through go_in.
// Notes:   Holds only the last descriptor control word written.
`timescale 1ns/100ps
`default_nettype none
module icd_mem_model (
  input  wire logic        clk_in,       // Clock
  input  wire logic        rst_in,       // Async reset, high
  input  wire logic        go_in,        // Finish a transfer
  input  wire logic        desc_wr_in,   // Descriptor word write
  input  wire logic [31:0] desc_word_in, // Descriptor word
  output logic             xfer_end_out, // Transfer end pulse
  output logic      [31:0] mem_word_out, // Stored word
  output logic      [7:0]  wr_cnt_out    // Writes seen
);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      xfer_end_out <= 1'b0;
      mem_word_out <= 32'h00000000;
      wr_cnt_out   <= 8'h00;
    end else begin
      xfer_end_out <= go_in;
      if (desc_wr_in) begin
        mem_word_out <= desc_word_in;
        wr_cnt_out   <= wr_cnt_out + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/tb_icd_dma_regs.sv
// Purpose: Self-checking bench for the DMA channel register block.
// Assumes: Avalon-MM master waits on waitrequest; byte lanes always full.
// Notes:   Register rows first, then channel, transfer and protection cases.
`timescale 1ns/100ps
`default_nettype none
module tb_icd_dma_regs;
  import icd_pkg::*;
  typedef struct packed { logic [4:0] a; logic [31:0] d; logic [31:0] e; } icd_row_t;
  localparam icd_row_t ROWS [8] = '{
    '{IDX_P_BASE, 32'hFFFFFFFF, 32'hFFFFFFFC}, '{IDX_C_BASE, 32'h12345677, 32'h12345674},
    '{IDX_P_DESC, 32'h0000ABCF, 32'h0000ABCC}, '{IDX_C_DESC, 32'hFFFFFFFF, 32'hFFFFFFFC},
    '{IDX_P_CTRL, 32'hFFFFFFFF, 32'h00000007}, '{IDX_C_CTRL, 32'h00000005, 32'h00000005},
    '{IDX_CHAN_STAT, 32'hFFFFFFFF, 32'h00000000}, '{5'h1F, 32'hFFFFFFFF, 32'h00000000}};
  logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, srst = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic [31:0] wdat = 32'h00000000;
  logic [3:0]  be = 4'hF;
  logic [1:0]  go = 2'h0;
  wire  logic [31:0] rdat, dw_p, dw_c, mw_p, mw_c;
  wire  logic        wait_r, p_st, c_st, sync, p_fe, c_fe, p_wr, c_wr, p_dn, c_dn, p_end, c_end;
  wire  logic [7:0]  wc_p, wc_c;
  wire  icd_prot_t   prot;
  int errors = 0, n_tests = 0;
  int dn [2] = '{0, 0};
  int i;
  logic [31:0] q;
  always #2 clk = ~clk;
  icd_dma_regs icd_dma_regs_i (.SYS_CLK_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdat), .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdat),
    .AVS_WAITREQUEST_OUT(wait_r), .SOFT_RST_EVENT_IN(srst), .PREVIEW_XFER_END_IN(p_end),
    .CODEC_XFER_END_IN(c_end), .PREVIEW_CHAN_STATE_OUT(p_st), .CODEC_CHAN_STATE_OUT(c_st),
    .SYNC_PENDING_OUT(sync), .PREVIEW_IMG_BASE_OUT(), .PREVIEW_DESC_PTR_OUT(), .CODEC_IMG_BASE_OUT(),
    .CODEC_DESC_PTR_OUT(), .PREVIEW_FETCH_EN_OUT(p_fe), .CODEC_FETCH_EN_OUT(c_fe), .PREVIEW_DESC_WR_OUT(p_wr),
    .CODEC_DESC_WR_OUT(c_wr), .PREVIEW_DESC_WORD_OUT(dw_p), .CODEC_DESC_WORD_OUT(dw_c),
    .PREVIEW_DONE_FLAG_OUT(p_dn), .CODEC_DONE_FLAG_OUT(c_dn), .PROT_CFG_OUT(prot));
  icd_mem_model icd_mem_model_i (.clk_in(clk), .rst_in(rst), .go_in(go[0]), .desc_wr_in(p_wr),
    .desc_word_in(dw_p), .xfer_end_out(p_end), .mem_word_out(mw_p), .wr_cnt_out(wc_p));
  icd_mem_model icd_mem_model_c_i (.clk_in(clk), .rst_in(rst), .go_in(go[1]), .desc_wr_in(c_wr),
    .desc_word_in(dw_c), .xfer_end_out(c_end), .mem_word_out(mw_c), .wr_cnt_out(wc_c));
  always @(posedge clk) begin
    if (p_dn === 1'b1) dn[0]++;
    if (c_dn === 1'b1) dn[1]++;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic timeout();
    errors++;
    $display("mismatch %0t wait timed out", $time);
    report_and_stop();
  endtask
  // Request held until waitrequest is seen low
  task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr   <= we;
    rd   <= !we;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (wait_r === 1'b0) break;
    end
    if (n == 50) timeout();
    r = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h00000000, r);
    chk(r, e);
  endtask
  task automatic wait_sync();
    int n;
    for (n = 0; n < 20; n++) begin
      @(negedge clk);
      if (sync === 1'b0) break;
    end
    if (n == 20) timeout();
  endtask
  task automatic pulse_srst();
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // One transfer end with a given control setting
  task automatic xfer(input int ch, input logic [2:0] c, input logic ed, input logic ew);
    int d0;
    logic [7:0] w0;
    wr_reg(ch ? IDX_C_CTRL : IDX_P_CTRL, {29'h0, c});
    d0 = dn[ch];
    w0 = ch ? wc_c : wc_p;
    @(posedge clk);
    go[ch] <= 1'b1;
    @(posedge clk);
    go[ch] <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'(dn[ch] - d0), {31'h0, ed});
    chk(32'(8'((ch ? wc_c : wc_p) - w0)), {31'h0, ew});
    if (ew) chk(ch ? mw_c : mw_p, {28'h0, 1'b1, c});
    chk({31'h0, ch ? c_fe : p_fe}, {31'h0, c[CTRL_FETCH]});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) rdchk(ROWS[i].a, RESET_WORD);
    for (i = 0; i < 8; i++) begin
      wr_reg(ROWS[i].a, ROWS[i].d);
      rdchk(ROWS[i].a, ROWS[i].e);
    end
    wr_reg(IDX_CHAN_ON, 32'h00000001);
    @(negedge clk);
    chk({31'h0, sync}, 32'h00000001);
    wr_reg(IDX_CHAN_ON, 32'h00000002);
    wait_sync();
    rdchk(IDX_CHAN_STAT, 32'h00000001);
    chk({30'h0, c_st, p_st}, 32'h00000001);
    wr_reg(IDX_CHAN_ON, 32'h00000000);
    rdchk(IDX_CHAN_STAT, 32'h00000001);
    wr_reg(IDX_CHAN_ON, 32'h00000002);
    wait_sync();
    rdchk(IDX_CHAN_STAT, 32'h00000003);
    xfer(0, 3'h3, 1'b1, 1'b1);
    xfer(0, 3'h7, 1'b0, 1'b1);
    xfer(0, 3'h0, 1'b1, 1'b0);
    xfer(1, 3'h3, 1'b1, 1'b1);
    xfer(1, 3'h4, 1'b0, 1'b0);
    wr_reg(IDX_CHAN_OFF, 32'h00000002);
    wait_sync();
    rdchk(IDX_CHAN_STAT, 32'h00000001);
    wr_reg(IDX_CHAN_OFF, 32'h00000001);
    wait_sync();
    rdchk(IDX_CHAN_STAT, 32'h00000000);
    wr_reg(IDX_PROT_LO, 32'h000000A5);
    rdchk(IDX_PROT_LO, 32'h000000A5);
    wr_reg(IDX_WP_CTRL, {24'h123456, 8'h01});
    rdchk(IDX_WP_CTRL, 32'h00000000);
    wr_reg(IDX_WP_CTRL, {WP_KEY, 8'h01});
    rdchk(IDX_WP_CTRL, 32'h00000001);
    wr_reg(IDX_PROT_HI, 32'h0000005A);
    rdchk(IDX_PROT_HI, 32'h00000000);
    chk(prot[8], 32'h00000000);
    rdchk(IDX_WP_STAT, 32'h00000901);
    rdchk(IDX_WP_STAT, 32'h00000000);
    pulse_srst();
    rdchk(IDX_WP_STAT, 32'h00000002);
    pulse_srst();
    wr_reg(IDX_PROT_LO, 32'h00000011);
    rdchk(IDX_WP_STAT, 32'h00000103);
    rdchk(IDX_PROT_LO, 32'h000000A5);
    wr_reg(IDX_WP_CTRL, {WP_KEY, 8'h00});
    rdchk(IDX_WP_CTRL, 32'h00000000);
    wr_reg(IDX_PROT_LO, 32'h00000077);
    rdchk(IDX_PROT_LO, 32'h00000077);
    pulse_srst();
    rdchk(IDX_WP_STAT, 32'h00000000);
    report_and_stop();
  end
endmodule
`default_nettype wire
